// [hw/fesc_pkg.sv]
// fesc_pkg: shared constants, register map and carrier types
// assumes a 32-bit AXI4-Lite register bus and one clock domain
package fesc_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] ADDR_HARD_STAT = 8'h00;
   localparam logic [7:0] ADDR_MM_STAT = 8'h04;
   localparam logic [7:0] ADDR_BUS_STAT = 8'h08;
   localparam logic [7:0] ADDR_USE_STAT = 8'h0c;
   localparam logic [7:0] ADDR_MM_ADDR = 8'h10;
   localparam logic [7:0] ADDR_BUS_ADDR = 8'h14;
   localparam logic [7:0] ADDR_PRIO = 8'h18;
   localparam logic [7:0] ADDR_ENABLE = 8'h1c;
   localparam logic [7:0] ADDR_SLEEP = 8'h20;
   localparam logic [7:0] ADDR_STATE = 8'h24;
   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int HF_VECTOR_READ_ERROR = 0;
   localparam int HF_ESC = 1;
   localparam int MM_IACC = 0;
   localparam int MM_DACC = 1;
   localparam int MM_STK = 2;
   localparam int MM_UNSTK = 3;
   localparam int BF_STK = 0;
   localparam int BF_UNSTK = 1;
   localparam int BF_PREF = 2;
   localparam int BF_PREC = 3;
   localparam int BF_IMPR = 4;
   localparam int UF_CP = 0;
   localparam int UF_UNDEFINED_INSTRUCTION_ERROR = 1;
   localparam int UF_STATE = 2;
   localparam int UF_RET = 3;
   localparam int UF_UNAL = 4;
   localparam int UF_DIVIDE_BY_ZERO_ERROR = 5;
   localparam int SC_ONEXIT = 1;
   localparam int SC_DEEP = 2;
   localparam int SC_EVPEND = 4;
   localparam int PRIO_W = 3;
   // fault kinds (index into priority and enable)
   localparam int FK_MM = 0;
   localparam int FK_BUS = 1;
   localparam int FK_USE = 2;
   localparam int NFK = 3;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ****************************************************************
   // carrier types
   // ****************************************************************
   typedef struct packed {
      logic vecRead;
      logic [3:0] mm;
      logic [4:0] bus;
      logic [5:0] usage;
      logic [31:0] addr;
   } fesc_err_s;
   typedef struct packed {
      logic handler;
      logic inNmi;
      logic inHard;
      logic [PRIO_W:0] curPrio;
      logic inFaultKindValid;
      logic [1:0] inFaultKind;
      logic busEntryStack;
   } fesc_ctx_s;
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_SLEEP = 3'b010,
      ST_LOCK = 3'b100
   } fesc_state_e;
endpackage

// [hw/fesc_core.sv]
// fesc_core: fault sorting, escalation, lockup and sleep control
// assumes pipeline, bus and interrupt controller on core_clk; the
// pipeline reports errors as one-cycle pulses with the access address
`timescale 1ns/1ps
// Summary of operation
// RL1 - bus error on vector fetch gives hard fault, sets vector read flag
// RL2 - any escalation to hard fault sets the escalation flag
// RL3 - bad instruction fetch, including never-execute, sets fetch flag
// RL4 - data, stacking, unstacking protection errors set own flags
// RL5 - five bus error kinds each set own bus fault flag
// RL6 - six usage causes each set own usage flag
// RL7 - non-native set or bad continuation return sets invalid state
// RL8 - configurable faults have priority and enable; hard fault fixed
// RL9 - handler repeating its own fault kind escalates to hard fault
// RL10 - fault not above current priority escalates to hard fault
// RL11 - fault with disabled handler escalates to hard fault
// RL12 - bus error stacking into bus handler does not escalate
// RL13 - only reset and nmi preempt hard fault; it preempts the rest
// RL14 - memory and non-imprecise bus faults capture address; others have none
// RL15 - hard fault inside nmi or hard handler enters lockup
// RL16 - lockup ends on reset, halt or nmi unless locked in nmi
// RL17 - light sleep stops core clock; deep stops system, pll, flash
// RL18 - wait-for-interrupt sleeps at once unless wake already true
// RL19 - wait-for-event consumes set event latch, else sleeps
// RL20 - sleep-on-exit sleeps on return to thread mode
// RL21 - wake only on sufficient priority; mask delays handler; the core also leaves sleep on debug halt
// RL22 - event wait also wakes on new pend when event-on-pend set
// RL23 - cause flags stay set until software clears them
module fesc_core
   import fesc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire fesc_err_s errIn,
   input wire fesc_ctx_s ctx,
   input wire logic waitIntInstr,
   input wire logic waitEventInstr,
   input wire logic sendEventInstr,
   input wire logic returnToThread,
   input wire logic excSufficient,
   input wire logic newPend,
   input wire logic nmiReq,
   input wire logic debugHalt,
   input wire logic primaryMask,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic hardFaultReq,
   output logic [NFK-1:0] faultReq,
   output logic lockup,
   output logic coreClkStop,
   output logic sysClkStop,
   output logic pllFlashOff,
   output logic handlerHold
);
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [1:0] hardStat;
   logic [3:0] mmStat;
   logic [4:0] busStat;
   logic [5:0] useStat;
   logic [31:0] mem_manage_fault_address;
   logic [31:0] busAddr;
   logic [NFK*PRIO_W-1:0] prioCfg;
   logic [NFK-1:0] enableCfg;
   logic [7:0] sleepCtrl;
   logic eventLatch;
   logic lockInNmi;
   fesc_state_e state;
   fesc_state_e next_state;
   // ****************************************************************
   // fault classification and escalation
   // ****************************************************************
   logic [NFK-1:0] kindHit;
   logic [NFK-1:0] escalate;
   logic anyEsc;
   logic hardNow;
   assign kindHit[FK_MM] = |errIn.mm; // RL3 RL4
   assign kindHit[FK_BUS] = |errIn.bus; // RL5
   assign kindHit[FK_USE] = |errIn.usage; // RL6 RL7
   genvar k;
   generate
      for (k = 0; k < NFK; k++) begin : g_esc
         logic [PRIO_W:0] kPrio;
         logic sameKind;
         logic notAbove;
         logic stackExempt;
         assign kPrio = {1'b0, prioCfg[k*PRIO_W +: PRIO_W]}; // RL8
         assign sameKind = ctx.inFaultKindValid &&
            (ctx.inFaultKind == 2'(k)); // RL9
         // lower number is higher priority, so equal or greater loses
         assign notAbove = ctx.handler && (kPrio >= ctx.curPrio); // RL10
         // stacking into the bus handler keeps the bus handler
         assign stackExempt = (k == FK_BUS) && ctx.busEntryStack; // RL12
         assign escalate[k] = kindHit[k] && !stackExempt &&
            (sameKind || notAbove || !enableCfg[k]); // RL9 RL11
      end
   endgenerate
   assign anyEsc = |escalate;
   assign hardNow = errIn.vecRead || anyEsc; // RL1
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hardFaultReq <= 1'b0;
         faultReq <= '0;
      end else begin
         // hard fault is a fixed level above every configurable one
         hardFaultReq <= hardNow; // RL13
         faultReq <= kindHit & ~escalate; // RL8
      end
   end
   // ****************************************************************
   // bus slave
   // ****************************************************************
   logic wrFire;
   logic wrMapped;
   logic wrTake;
   logic rdMapped;
   logic [7:0] wrAddr;
   logic clrHard;
   logic clrMm;
   logic clrBus;
   logic clrUse;
   logic [31:0] rdMux;
   assign wrFire = awvalid && wvalid && awready && wready;
   assign wrAddr = awaddr[7:0];
   // an unmapped access answers with an error and touches nothing
   assign wrMapped = (awaddr[31:8] == '0) && (wrAddr <= ADDR_STATE) &&
      (wrAddr[1:0] == 2'b00);
   assign wrTake = wrFire && wrMapped && wstrb[0];
   assign rdMapped = (araddr[31:8] == '0) &&
      (araddr[7:0] <= ADDR_STATE) && (araddr[1:0] == 2'b00);
   assign clrHard = wrTake && (wrAddr == ADDR_HARD_STAT);
   assign clrMm = wrTake && (wrAddr == ADDR_MM_STAT);
   assign clrBus = wrTake && (wrAddr == ADDR_BUS_STAT);
   assign clrUse = wrTake && (wrAddr == ADDR_USE_STAT);
   // address and data taken together keeps the slave single-state
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         awready <= awvalid && wvalid && !awready && !bvalid;
         wready <= awvalid && wvalid && !awready && !bvalid;
         if (wrFire) begin
            bvalid <= 1'b1;
            bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prioCfg <= '0;
         enableCfg <= '0;
         sleepCtrl <= '0;
      end else if (wrTake) begin
         unique case (wrAddr)
            ADDR_PRIO: prioCfg <= wdata[NFK*PRIO_W-1:0];
            ADDR_ENABLE: enableCfg <= wdata[NFK-1:0];
            ADDR_SLEEP: sleepCtrl <= wdata[7:0];
            default: ;
         endcase
      end
   end
   always_comb begin
      rdMux = '0;
      unique case (araddr[7:0])
         ADDR_HARD_STAT: rdMux = 32'(hardStat);
         ADDR_MM_STAT: rdMux = 32'(mmStat);
         ADDR_BUS_STAT: rdMux = 32'(busStat);
         ADDR_USE_STAT: rdMux = 32'(useStat);
         ADDR_MM_ADDR: rdMux = mem_manage_fault_address;
         ADDR_BUS_ADDR: rdMux = busAddr;
         ADDR_PRIO: rdMux = 32'(prioCfg);
         ADDR_ENABLE: rdMux = 32'(enableCfg);
         ADDR_SLEEP: rdMux = 32'(sleepCtrl);
         ADDR_STATE: rdMux = {28'h0000000, eventLatch, state};
         default: rdMux = '0;
      endcase
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else begin
         arready <= arvalid && !arready && !rvalid;
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rdMapped ? rdMux : '0;
            rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end
   // ****************************************************************
   // sticky cause flags and fault addresses
   // ****************************************************************
   // write one to clear; a new event in the same cycle wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hardStat <= '0;
         mmStat <= '0;
         busStat <= '0;
         useStat <= '0;
      end else begin
         hardStat <= (hardStat & ~({2{clrHard}} & wdata[1:0])) |
            {anyEsc, errIn.vecRead}; // RL1 RL2 RL23
         mmStat <= (mmStat & ~({4{clrMm}} & wdata[3:0])) |
            errIn.mm; // RL3 RL4 RL23
         busStat <= (busStat & ~({5{clrBus}} & wdata[4:0])) |
            errIn.bus; // RL5 RL23
         useStat <= (useStat & ~({6{clrUse}} & wdata[5:0])) |
            errIn.usage; // RL6 RL7 RL23
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_manage_fault_address <= '0;
         busAddr <= '0;
      end else begin
         // imprecise errors carry no trustworthy address
         if (kindHit[FK_MM]) mem_manage_fault_address <= errIn.addr; // RL14
         if (|(errIn.bus & ~(5'h01 << BF_IMPR))) busAddr <= errIn.addr; // RL14
      end
   end
   // ****************************************************************
   // event latch
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         eventLatch <= 1'b0;
      end else if (sendEventInstr ||
         (sleepCtrl[SC_EVPEND] && newPend)) begin
         eventLatch <= 1'b1; // RL22
      end else if (waitEventInstr && state == ST_RUN) begin
         eventLatch <= 1'b0; // RL19
      end
   end
   // ****************************************************************
   // run, sleep and lockup
   // ****************************************************************
   logic sleepByEvent;
   logic wakeNow;
   logic enterLock;
   assign enterLock = hardNow && (ctx.inNmi || ctx.inHard); // RL15
   assign wakeNow = excSufficient ||
      (sleepByEvent && sleepCtrl[SC_EVPEND] && newPend); // RL21 RL22
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (enterLock) begin
               next_state = ST_LOCK;
            end else if (waitIntInstr && !excSufficient) begin
               next_state = ST_SLEEP; // RL18
            end else if (waitEventInstr && !eventLatch &&
               !excSufficient) begin
               next_state = ST_SLEEP; // RL19
            end else if (returnToThread && sleepCtrl[SC_ONEXIT] &&
               !excSufficient) begin
               next_state = ST_SLEEP; // RL20
            end
         end
         ST_SLEEP: begin
            if (wakeNow || debugHalt) next_state = ST_RUN;
         end
         ST_LOCK: begin
            if (debugHalt || (nmiReq && !lockInNmi)) begin
               next_state = ST_RUN; // RL16
            end
         end
         default: next_state = ST_RUN;
      endcase
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_RUN;
         lockInNmi <= 1'b0;
         sleepByEvent <= 1'b0;
      end else begin
         state <= next_state;
         if (state == ST_RUN && enterLock) lockInNmi <= ctx.inNmi; // RL16
         if (state == ST_RUN) sleepByEvent <= waitEventInstr;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lockup <= 1'b0;
         coreClkStop <= 1'b0;
         sysClkStop <= 1'b0;
         pllFlashOff <= 1'b0;
         handlerHold <= 1'b0;
      end else begin
         lockup <= (next_state == ST_LOCK);
         coreClkStop <= (next_state == ST_SLEEP); // RL17
         sysClkStop <= (next_state == ST_SLEEP) && sleepCtrl[SC_DEEP];
         pllFlashOff <= (next_state == ST_SLEEP) && sleepCtrl[SC_DEEP];
         // woken with the mask set: run, but keep the handler waiting
         handlerHold <= primaryMask && (state == ST_SLEEP ||
            handlerHold) && excSufficient; // RL21
      end
   end
   // ****************************************************************
   // checks
   // ****************************************************************
   property p_vector_read_error;
      @(posedge core_clk) disable iff (!rst_n)
      errIn.vecRead |=> hardStat[HF_VECTOR_READ_ERROR] && hardFaultReq;
   endproperty
   a_vector_read_error: assert property (p_vector_read_error) else $error("vector flag"); // RL1
   property p_esc;
      @(posedge core_clk) disable iff (!rst_n)
      anyEsc |=> hardStat[HF_ESC] && hardFaultReq;
   endproperty
   a_esc: assert property (p_esc) else $error("escalation flag"); // RL2
   property p_dis;
      @(posedge core_clk) disable iff (!rst_n)
      (errIn.usage != '0 && !enableCfg[FK_USE]) |=>
         !faultReq[FK_USE] && hardFaultReq;
   endproperty
   a_dis: assert property (p_dis) else $error("disabled escalate"); // RL11
   property p_stk;
      @(posedge core_clk) disable iff (!rst_n)
      (ctx.busEntryStack && errIn.bus != '0 && !anyEsc &&
         !errIn.vecRead) |=> faultReq[FK_BUS] && !hardFaultReq;
   endproperty
   a_stk: assert property (p_stk) else $error("stack exempt"); // RL12
   property p_bad;
      @(posedge core_clk) disable iff (!rst_n)
      (errIn.bus[BF_PREC]) |=> busAddr == $past(errIn.addr);
   endproperty
   a_bad: assert property (p_bad) else $error("bus address"); // RL14
   sequence s_lockEnter;
      state == ST_RUN && enterLock;
   endsequence
   property p_lock;
      @(posedge core_clk) disable iff (!rst_n)
      s_lockEnter |=> state == ST_LOCK ##1 lockup;
   endproperty
   a_lock: assert property (p_lock) else $error("lockup entry"); // RL15
   property p_nmi;
      @(posedge core_clk) disable iff (!rst_n)
      (state == ST_LOCK && lockInNmi && !debugHalt) |=> state == ST_LOCK;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi release"); // RL16
   property p_wfe;
      @(posedge core_clk) disable iff (!rst_n)
      (state == ST_RUN && waitEventInstr && eventLatch && !enterLock &&
         !waitIntInstr && !returnToThread && !sendEventInstr &&
         !(sleepCtrl[SC_EVPEND] && newPend)) |=>
         state == ST_RUN && !eventLatch;
   endproperty
   a_wfe: assert property (p_wfe) else $error("event consume"); // RL19
   property p_deep;
      @(posedge core_clk) disable iff (!rst_n)
      sysClkStop |-> coreClkStop && pllFlashOff;
   endproperty
   a_deep: assert property (p_deep) else $error("deep sleep"); // RL17
endmodule

// [bench/fesc_far_model.sv]
// fesc_far_model: stand-in for pipeline, bus and interrupt controller
// assumes the bench calls its tasks; every change follows a core_clk edge
`timescale 1ns/1ps
module fesc_far_model
   import fesc_pkg::*;
(
   input wire logic core_clk,
   output fesc_err_s errIn,
   output fesc_ctx_s ctx,
   output logic [3:0] instr,
   output logic [4:0] lvl
);
   // instr: 0 wait-int, 1 wait-event, 2 send-event, 3 return to thread
   // lvl: 4 sufficient, 3 new pend, 2 nmi, 1 debug halt, 0 primary mask
   initial begin
      errIn = '0;
      ctx = '0;
      instr = '0;
      lvl = '0;
   end
   // released address lines invert, so a held value never passes
   task automatic pulseErr(input fesc_err_s e);
      fesc_err_s idle;
      idle = '0;
      idle.addr = ~e.addr;
      @(posedge core_clk);
      errIn <= e;
      @(posedge core_clk);
      errIn <= idle;
   endtask
   task automatic pulseInstr(input logic [3:0] m);
      @(posedge core_clk);
      instr <= m;
      @(posedge core_clk);
      instr <= 4'h0;
   endtask
   task automatic setCtx(input fesc_ctx_s c);
      @(posedge core_clk);
      ctx <= c;
   endtask
   task automatic setLvl(input logic [4:0] v);
      @(posedge core_clk);
      lvl <= v;
   endtask
endmodule

// [bench/test_fault_escalation_sleep_ctrl.sv]
// test_fault_escalation_sleep_ctrl: self-checking bench for fesc_core
// assumes fesc_pkg and the far-side model; registers over AXI4-Lite
`timescale 1ns/1ps
module test_fault_escalation_sleep_ctrl
   import fesc_pkg::*;
();
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   fesc_err_s errIn;
   fesc_ctx_s ctx;
   logic [3:0] instr;
   logic [4:0] lvl;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [3:0] wrStrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic hardFaultReq, lockup, coreClkStop, sysClkStop;
   logic pllFlashOff, handlerHold;
   logic [NFK-1:0] faultReq;
   int errCount = 0;
   int samplesChecked = 0;
   always #2 core_clk = ~core_clk;
   fesc_far_model i_far (.core_clk(core_clk), .errIn(errIn), .ctx(ctx),
      .instr(instr), .lvl(lvl));
   fesc_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .errIn(errIn),
      .ctx(ctx), .waitIntInstr(instr[0]), .waitEventInstr(instr[1]),
      .sendEventInstr(instr[2]), .returnToThread(instr[3]),
      .excSufficient(lvl[4]), .newPend(lvl[3]), .nmiReq(lvl[2]),
      .debugHalt(lvl[1]), .primaryMask(lvl[0]), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wrStrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .hardFaultReq(hardFaultReq), .faultReq(faultReq), .lockup(lockup),
      .coreClkStop(coreClkStop), .sysClkStop(sysClkStop),
      .pllFlashOff(pllFlashOff), .handlerHold(handlerHold));
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] got,
         input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // no cycle limit here: only the watchdog ends a stuck handshake
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er = RESP_OKAY, input logic [23:0] hi = 24'h0);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge core_clk);
      awaddr <= {hi, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awready === 1'b1) ad = 1'b1;
         if (wready === 1'b1) wd = 1'b1;
         if (ad) awvalid <= 1'b0;
         if (wd) wvalid <= 1'b0;
      end while (!(ad && wd));
      do @(posedge core_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", 32'(bresp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
         input logic [1:0] er = RESP_OKAY, input logic [23:0] hi = 24'h0);
      @(posedge core_clk);
      araddr <= {hi, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk($sformatf("rdata at %h", a), rdata, ed);
      chk("rresp", 32'(rresp), 32'(er));
   endtask
   task automatic settle();
      @(posedge core_clk);
      #1;
   endtask
   task automatic flt(input fesc_err_s e, input logic h,
         input logic [2:0] f);
      i_far.pulseErr(e);
      #1;
      chk("hardFaultReq", 32'(hardFaultReq), 32'(h));
      chk("faultReq", 32'(faultReq), 32'(f));
   endtask
   function automatic fesc_err_s mkErr(input int b, input logic [31:0] a);
      fesc_err_s e;
      e = '0;
      {e.mm, e.bus, e.usage} = 15'h1 << b;
      e.addr = a;
      return e;
   endfunction
   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      fesc_err_s vec;
      fesc_ctx_s c;
      int k, bt;
      logic [7:0] ra;
      logic [31:0] fa, lastBus;
      vec = '0;
      vec.vecRead = 1'b1;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++) rd(8'(i * 4), (i == 9) ? 32'h1 : 32'h0);
      rd(8'h28, 32'h0, RESP_SLVERR);
      wr(8'h2c, 32'h1, RESP_SLVERR);
      wr(ADDR_ENABLE, 32'h7);
      wr(ADDR_PRIO, 32'h49);
      rd(ADDR_PRIO, 32'h49);
      // low strobe or high address bits must leave the enables alone
      wrStrb <= 4'he;
      wr(ADDR_ENABLE, 32'h0);
      wrStrb <= 4'hf;
      rd(ADDR_ENABLE, 32'h7);
      wr(ADDR_ENABLE, 32'h0, RESP_SLVERR, 24'h1);
      rd(ADDR_ENABLE, 32'h7);
      rd(ADDR_ENABLE, 32'h0, RESP_SLVERR, 24'h1);
      $display("test registers done");
      lastBus = '0;
      for (int b = 0; b < 15; b++) begin
         k = (b < 6) ? FK_USE : (b < 11) ? FK_BUS : FK_MM;
         bt = (b < 6) ? b : (b < 11) ? b - 6 : b - 11;
         ra = (b < 6) ? ADDR_USE_STAT :
            (b < 11) ? ADDR_BUS_STAT : ADDR_MM_STAT;
         fa = 32'h2000_0100 + 32'(b * 4);
         flt(mkErr(b, fa), 1'b0, 3'(1 << k));
         rd(ra, 32'h1 << bt);
         rd(ra, 32'h1 << bt);
         if (k == FK_MM) rd(ADDR_MM_ADDR, fa);
         if (k == FK_BUS && bt != BF_IMPR) lastBus = fa;
         if (k == FK_BUS) rd(ADDR_BUS_ADDR, lastBus);
         wr(ra, 32'h1 << bt);
         rd(ra, 32'h0);
      end
      $display("test fault causes done");
      flt(vec, 1'b1, 3'h0);
      rd(ADDR_HARD_STAT, 32'h1);
      wr(ADDR_ENABLE, 32'h3);
      flt(mkErr(UF_UNDEFINED_INSTRUCTION_ERROR, 32'h0), 1'b1, 3'h0);
      rd(ADDR_HARD_STAT, 32'h3);
      wr(ADDR_ENABLE, 32'h7);
      wr(ADDR_PRIO, 32'hca);
      c = '0;
      c.handler = 1'b1;
      c.curPrio = 4'd2;
      i_far.setCtx(c);
      flt(mkErr(UF_UNDEFINED_INSTRUCTION_ERROR, 32'h0), 1'b1, 3'h0);
      flt(mkErr(6 + BF_PREC, 32'h0), 1'b0, 3'h2);
      flt(mkErr(11 + MM_DACC, 32'h0), 1'b1, 3'h0);
      c.curPrio = 4'd4;
      c.inFaultKindValid = 1'b1;
      c.inFaultKind = 2'(FK_BUS);
      i_far.setCtx(c);
      flt(mkErr(6 + BF_PREC, 32'h0), 1'b1, 3'h0);
      c.busEntryStack = 1'b1;
      i_far.setCtx(c);
      flt(mkErr(6 + BF_STK, 32'h0), 1'b0, 3'h2);
      for (int i = 0; i < 4; i++) wr(8'(i * 4), 32'hff);
      rd(ADDR_HARD_STAT, 32'h0);
      $display("test escalation done");
      c = '0;
      c.handler = 1'b1;
      c.inHard = 1'b1;
      i_far.setCtx(c);
      flt(vec, 1'b1, 3'h0);
      settle();
      chk("lockup", 32'(lockup), 32'h1);
      rd(ADDR_STATE, 32'h4);
      i_far.setLvl(5'h04);
      i_far.setLvl(5'h00);
      settle();
      chk("lockup", 32'(lockup), 32'h0);
      c.inHard = 1'b0;
      c.inNmi = 1'b1;
      i_far.setCtx(c);
      flt(vec, 1'b1, 3'h0);
      i_far.setLvl(5'h04);
      i_far.setLvl(5'h00);
      settle();
      chk("lockup", 32'(lockup), 32'h1);
      i_far.setLvl(5'h02);
      i_far.setLvl(5'h00);
      settle();
      chk("lockup", 32'(lockup), 32'h0);
      i_far.setCtx('0);
      wr(ADDR_HARD_STAT, 32'hff);
      $display("test lockup done");
      i_far.pulseInstr(4'h1);
      settle();
      chk("coreClkStop", 32'(coreClkStop), 32'h1);
      chk("sysClkStop", 32'(sysClkStop), 32'h0);
      i_far.setLvl(5'h10);
      settle();
      chk("coreClkStop", 32'(coreClkStop), 32'h0);
      i_far.pulseInstr(4'h1);
      settle();
      chk("coreClkStop", 32'(coreClkStop), 32'h0);
      i_far.setLvl(5'h00);
      wr(ADDR_SLEEP, 32'h1 << SC_DEEP);
      i_far.pulseInstr(4'h1);
      settle();
      chk("sysClkStop", 32'(sysClkStop), 32'h1);
      chk("pllFlashOff", 32'(pllFlashOff), 32'h1);
      rd(ADDR_STATE, 32'h2);
      i_far.setLvl(5'h11);
      settle();
      chk("sysClkStop", 32'(sysClkStop), 32'h0);
      chk("handlerHold", 32'(handlerHold), 32'h1);
      i_far.setLvl(5'h00);
      settle();
      chk("handlerHold", 32'(handlerHold), 32'h0);
      wr(ADDR_SLEEP, 32'h0);
      i_far.pulseInstr(4'h4);
      rd(ADDR_STATE, 32'h9);
      i_far.pulseInstr(4'h2);
      settle();
      chk("coreClkStop", 32'(coreClkStop), 32'h0);
      rd(ADDR_STATE, 32'h1);
      i_far.pulseInstr(4'h2);
      settle();
      chk("coreClkStop", 32'(coreClkStop), 32'h1);
      i_far.setLvl(5'h08);
      settle();
      chk("coreClkStop", 32'(coreClkStop), 32'h1);
      i_far.setLvl(5'h00);
      wr(ADDR_SLEEP, 32'h1 << SC_EVPEND);
      i_far.setLvl(5'h08);
      settle();
      chk("coreClkStop", 32'(coreClkStop), 32'h0);
      i_far.setLvl(5'h00);
      i_far.pulseInstr(4'h8);
      settle();
      chk("coreClkStop", 32'(coreClkStop), 32'h0);
      wr(ADDR_SLEEP, 32'h1 << SC_ONEXIT);
      i_far.pulseInstr(4'h8);
      settle();
      chk("coreClkStop", 32'(coreClkStop), 32'h1);
      $display("test sleep done");
      give_verdict();
   end
   // whole run is under a thousand cycles; this span is far beyond it
   initial begin
      #300000;
      errCount++;
      give_verdict();
   end
endmodule
